/* hw/tcap_map.svh */
// register offsets, field positions and timing for the capture/pulse timer
// assumes a 32-bit apb slave with word-aligned registers
`ifndef TCAP_MAP_SVH
`define TCAP_MAP_SVH
`define CTRL_OFS 12'h000
`define CMPA_OFS 12'h004
`define CMPB_OFS 12'h008
`define STAT_OFS 12'h00c
`define CTRL_START_LSB 4
`define CTRL_MODE_LSB 0
`define CTRL_CLKSEL_LSB 2
`define CTRL_FLOP_BIT 7
`define CTRL_EDGEMODE_BIT 8
`define CTRL_REPEAT_BIT 9
`define CTRL_ACAP_BIT 6
`define CTRL_MEASURE_BIT 10
`define CTRL_RESET 32'h00000000
`define CMP_RESET 16'hffff
`define DIV0 12'h7ff
`define DIV1 12'h07f
`define DIV2 12'h007
`endif

/* hw/tcap_pkg.sv */
// types for the capture/pulse timer
// assumes tcap_map.svh supplies numeric constants
package tcap_pkg;
  typedef enum logic [1:0] {MODE_TIMER, MODE_EVENT, MODE_WINDOW, MODE_PULSE} mode_t;
  typedef struct packed {
    logic measureSel;
    logic [1:0] startCtl;
    logic [1:0] clkSel;
    logic [1:0] modeSel;
    logic flopCtl;
    logic autoCapture;
    logic edgeMode;
    logic repeatSel;
  } ctrl_t;
endpackage

/* hw/tick_divider.sv */
// source clock enable divider for the timer
// assumes one system clock; emits one-cycle enables
`timescale 1ns/1ps
`include "tcap_map.svh"
module tick_divider (
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] clkSel,
  output logic tick
);
  logic [11:0] cnt_q;
  logic [11:0] limit;
  always_comb begin
    case (clkSel)
      2'h0: limit = `DIV0;
      2'h1: limit = `DIV1;
      default: limit = `DIV2;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset || cnt_q >= limit) begin
      cnt_q <= 12'h000;
    end else begin
      cnt_q <= cnt_q + 12'h001;
    end
  end
  always_ff @(posedge clk) begin
    tick <= !reset && (cnt_q == limit);
  end
endmodule

/* hw/timer_counter_capture_pulse_gen.sv */
// 16-bit counter: event, window, pulse-width and pulse generation modes
// assumes apb master at 40 MHz; counter input synchronous to clk
// Summary of operation
// - event edges count; match A interrupts, clears
// - match A checked on opposite input edge
// - auto-capture copies count to B each running tick outside mode 3
// - window mode counts ticks while pin high
// - window match A interrupts and clears counter
// - width mode starts on selected trigger edge
// - single-edge: capture, interrupt, set count to one, wait trigger
// - single-edge counter holds at one after capture
// - double-edge: capture both edges, clear on trigger
// - pulse mode starts by edge or command
// - continuous: invert on B, invert on A, clear
// - start cleared: stop, hold output level
// - one-shot: invert on A, self-clear start, stop
// - output pin is inverse of output flop
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "tcap_map.svh"
module timer_counter_capture_pulse_gen
  import tcap_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic counterInputPin,
  output logic invertedPulseOutput,
  output logic counterInterrupt
);
  ctrl_t ctrl_q;
  logic [15:0] count_q;
  logic [15:0] cmpA_q;
  logic [15:0] cmpB_q;
  logic flop_q;
  logic pin_q;
  logic running_q;
  logic armed_q;
  logic phase_q;
  logic tick;
  logic rise;
  logic fall;
  logic trigEdge;
  logic oppEdge;
  logic matchA;
  logic matchB;
  logic stopReq;
  logic wr;
  logic rd;
  logic pulseMode;
  mode_t mode;

  tick_divider u_div (
    .clk(clk),
    .reset(reset),
    .clkSel(ctrl_q.clkSel),
    .tick(tick)
  );

  assign mode = mode_t'(ctrl_q.modeSel);
  assign rise = counterInputPin && !pin_q;
  assign fall = !counterInputPin && pin_q;
  // start field 01 picks rising, otherwise falling; 11 is command start in pulse mode
  assign trigEdge = (ctrl_q.startCtl == 2'h1) ? rise : fall;
  assign oppEdge = (ctrl_q.startCtl == 2'h1) ? fall : rise;
  assign matchA = (count_q == cmpA_q);
  assign matchB = (count_q == cmpB_q);
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  // mode 3 with the measure bit set is width measurement, clear is pulse generation
  assign pulseMode = mode == MODE_PULSE && !ctrl_q.measureSel;
  assign stopReq = pulseMode && ctrl_q.repeatSel && running_q && tick && matchA;

  always_ff @(posedge clk) begin
    pin_q <= reset ? 1'b0 : counterInputPin;
  end

  // control register; hardware one-shot stop clears the start field
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= ctrl_t'(11'(`CTRL_RESET));
    end else if (stopReq) begin
      ctrl_q.startCtl <= 2'h0;
    end else if (wr && paddr == `CTRL_OFS) begin
      ctrl_q.startCtl <= pwdata[`CTRL_START_LSB +: 2];
      ctrl_q.clkSel <= pwdata[`CTRL_CLKSEL_LSB +: 2];
      ctrl_q.modeSel <= pwdata[`CTRL_MODE_LSB +: 2];
      ctrl_q.flopCtl <= pwdata[`CTRL_FLOP_BIT];
      ctrl_q.autoCapture <= pwdata[`CTRL_ACAP_BIT];
      ctrl_q.edgeMode <= pwdata[`CTRL_EDGEMODE_BIT];
      ctrl_q.repeatSel <= pwdata[`CTRL_REPEAT_BIT];
      ctrl_q.measureSel <= pwdata[`CTRL_MEASURE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cmpA_q <= `CMP_RESET;
    end else if (wr && paddr == `CMPA_OFS) begin
      cmpA_q <= pwdata[15:0];
    end
  end

  // running state: event/window/width run at once, pulse generation waits for trigger or command
  always_ff @(posedge clk) begin
    if (reset || ctrl_q.startCtl == 2'h0) begin
      running_q <= 1'b0;
    end else if (pulseMode && !running_q) begin
      running_q <= (ctrl_q.startCtl == 2'h3) || trigEdge;
    end else if (!pulseMode) begin
      running_q <= 1'b1;
    end
  end

  // counter, capture and interrupt
  always_ff @(posedge clk) begin
    if (reset) begin
      count_q <= 16'h0000;
      cmpB_q <= `CMP_RESET;
      counterInterrupt <= 1'b0;
      armed_q <= 1'b0;
      phase_q <= 1'b0;
    end else begin
      counterInterrupt <= 1'b0;
      if (wr && paddr == `CMPB_OFS) begin
        cmpB_q <= pwdata[15:0];
      end
      if (!running_q) begin
        if (ctrl_q.startCtl == 2'h0) begin
          count_q <= 16'h0000;
          armed_q <= 1'b0;
          phase_q <= 1'b0;
        end
      end else begin
        case (mode)
          MODE_EVENT: begin
            if (trigEdge) begin
              count_q <= count_q + 16'h0001;
            end else if (oppEdge && matchA) begin
              count_q <= 16'h0000;
              counterInterrupt <= 1'b1;
            end
          end
          MODE_WINDOW: begin
            if (tick && pin_q) begin
              if (matchA) begin
                count_q <= 16'h0000;
                counterInterrupt <= 1'b1;
              end else begin
                count_q <= count_q + 16'h0001;
              end
            end
          end
          MODE_PULSE: begin
            if (!ctrl_q.measureSel) begin
              if (tick) begin
                count_q <= matchA ? 16'h0000 : count_q + 16'h0001;
                counterInterrupt <= matchA || matchB;
              end
            end else if (ctrl_q.edgeMode) begin
              if (!armed_q && trigEdge) begin
                armed_q <= 1'b1;
              end else if (armed_q && oppEdge) begin
                cmpB_q <= count_q;
                counterInterrupt <= 1'b1;
                count_q <= 16'h0001;
                armed_q <= 1'b0;
              end else if (armed_q && tick) begin
                count_q <= count_q + 16'h0001;
              end
            end else begin
              if (!armed_q && trigEdge) begin
                armed_q <= 1'b1;
              end else if (armed_q && oppEdge && !phase_q) begin
                cmpB_q <= count_q;
                counterInterrupt <= 1'b1;
                phase_q <= 1'b1;
              end else if (armed_q && trigEdge && phase_q) begin
                cmpB_q <= count_q;
                counterInterrupt <= 1'b1;
                count_q <= 16'h0000;
                phase_q <= 1'b0;
              end else if (armed_q && tick) begin
                count_q <= count_q + 16'h0001;
              end
            end
          end
          default: begin
            if (tick) begin
              count_q <= matchA ? 16'h0000 : count_q + 16'h0001;
              counterInterrupt <= matchA;
            end
          end
        endcase
        if (ctrl_q.autoCapture && tick && mode != MODE_PULSE) begin
          cmpB_q <= count_q;
        end
      end
    end
  end

  // output flop: preset only from timer mode, so a stopped pulse keeps its level
  always_ff @(posedge clk) begin
    if (reset) begin
      flop_q <= 1'b0;
    end else if (mode == MODE_TIMER && wr && paddr == `CTRL_OFS) begin
      flop_q <= pwdata[`CTRL_FLOP_BIT];
    end else if (mode == MODE_TIMER) begin
      flop_q <= ctrl_q.flopCtl;
    end else if (pulseMode && running_q && tick && (matchB || matchA)) begin
      flop_q <= !flop_q;
    end
  end

  always_ff @(posedge clk) begin
    invertedPulseOutput <= reset ? 1'b1 : !flop_q;
  end

  // apb read data and ready: no wait states, no errors
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (rd) begin
        case (paddr)
          `CTRL_OFS: prdata <= {21'h000000, ctrl_q.measureSel, ctrl_q.repeatSel, ctrl_q.edgeMode,
                                ctrl_q.flopCtl, ctrl_q.autoCapture, ctrl_q.startCtl,
                                ctrl_q.clkSel, ctrl_q.modeSel};
          `CMPA_OFS: prdata <= {16'h0000, cmpA_q};
          `CMPB_OFS: prdata <= {16'h0000, cmpB_q};
          `STAT_OFS: prdata <= {14'h0000, flop_q, running_q, count_q};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  property p_ppg_toggle;
    @(posedge clk) disable iff (reset)
      (pulseMode && running_q && tick && (matchA || matchB))
        |=> flop_q != $past(flop_q) && counterInterrupt;
  endproperty
  a_ppg_toggle: assert property (p_ppg_toggle) else $error("pulse edge missed");

  property p_one_shot_stop;
    @(posedge clk) disable iff (reset) stopReq |=> ctrl_q.startCtl == 2'h0;
  endproperty
  a_one_shot_stop: assert property (p_one_shot_stop) else $error("one-shot did not stop");

  property p_output_inverse;
    @(posedge clk) disable iff (reset) 1'b1 |=> invertedPulseOutput == !$past(flop_q);
  endproperty
  a_output_inverse: assert property (p_output_inverse) else $error("output not inverse");

  property p_hold_stopped;
    @(posedge clk) disable iff (reset)
      (mode == MODE_PULSE && !running_q && $past(!running_q)) |=> $stable(flop_q);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("output moved while stopped");

  property p_window_clear;
    @(posedge clk) disable iff (reset)
      (running_q && mode == MODE_WINDOW && tick && pin_q && matchA)
        |=> count_q == 16'h0000 && counterInterrupt;
  endproperty
  a_window_clear: assert property (p_window_clear) else $error("window match missed");

  property p_window_gate;
    @(posedge clk) disable iff (reset)
      (running_q && mode == MODE_WINDOW && !pin_q && !$past(reset)) |=> $stable(count_q);
  endproperty
  a_window_gate: assert property (p_window_gate) else $error("counted outside window");

  property p_event_count;
    @(posedge clk) disable iff (reset)
      (running_q && mode == MODE_EVENT && trigEdge) |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_event_count: assert property (p_event_count) else $error("event not counted");

  property p_event_irq_edge;
    @(posedge clk) disable iff (reset)
      (mode == MODE_EVENT && counterInterrupt) |-> $past(oppEdge);
  endproperty
  a_event_irq_edge: assert property (p_event_irq_edge) else $error("irq on wrong edge");

  property p_single_hold;
    @(posedge clk) disable iff (reset)
      (running_q && mode == MODE_PULSE && ctrl_q.edgeMode && armed_q && oppEdge)
        |=> count_q == 16'h0001 && counterInterrupt;
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("single-edge hold wrong");

  property p_autocap;
    @(posedge clk) disable iff (reset)
      (running_q && ctrl_q.autoCapture && tick && mode == MODE_EVENT && !trigEdge
       && !oppEdge && !(wr && paddr == `CMPB_OFS)) |=> cmpB_q == $past(count_q);
  endproperty
  a_autocap: assert property (p_autocap) else $error("auto-capture missed");

  c_one_shot: cover property (@(posedge clk) stopReq);
  c_window_irq: cover property (@(posedge clk) mode == MODE_WINDOW && counterInterrupt);
  c_width_capture: cover property (@(posedge clk) mode == MODE_PULSE && counterInterrupt);
endmodule

/* bench/pulse_source.sv */
// far-side model: external pulse source on the counter input pin
// assumes the bench calls its tasks from one process, on clk edges
`timescale 1ns/1ps
module pulse_source (
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;
  // each phase lasts at least eight cycles, slow next to the source clock
  task automatic level(input logic v, input int n);
    @(posedge clk);
    pin <= v;
    repeat (((n < 8) ? 8 : n) - 1) @(posedge clk);
  endtask
  task automatic pulse(input int hi, input int lo);
    level(1'b1, hi);
    level(1'b0, lo);
  endtask
endmodule

/* bench/timer_counter_capture_pulse_gen_tb_top.sv */
// self-checking bench for the capture/pulse timer
// assumes apb slave answers in its access cycle; source clock select 2 is /8
`timescale 1ns/1ps
`include "tcap_map.svh"
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin numErrors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module timer_counter_capture_pulse_gen_tb_top;
  import tcap_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic counterInputPin;
  logic invertedPulseOutput;
  logic counterInterrupt;
  logic outQ = 1'b1;
  logic [15:0] b1;
  int numErrors = 0;
  int checkCount = 0;
  int irqCount = 0;
  int togCount = 0;
  int i0;
  int t0;
  row_t rows[4] = '{'{12'h000, 32'h0000020e, 32'h0000020e},
    '{12'h004, 32'h00001234, 32'h00001234}, '{12'h004, 32'h00000003, 32'h00000003},
    '{12'h010, 32'h00005a5a, 32'h00000000}};
  timer_counter_capture_pulse_gen dut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counterInputPin(counterInputPin), .invertedPulseOutput(invertedPulseOutput),
    .counterInterrupt(counterInterrupt));
  pulse_source src (.clk(clk), .pin(counterInputPin));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (counterInterrupt === 1'b1) irqCount <= irqCount + 1;
    if (invertedPulseOutput !== outQ) togCount <= togCount + 1;
    outQ <= invertedPulseOutput;
  end
  function automatic logic [31:0] ctl(input logic [1:0] m, c, s, input logic a, f, e, r,
                                      input logic w = 1'b0);
    return {21'h0, w, r, e, f, a, s, c, m};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) numErrors++;
    rd = prdata;
    `CHK("pslverr", 1'b0, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic endOfTest;
    $display("errors %0d checks %0d", numErrors, checkCount);
    if (numErrors == 0 && checkCount > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    endOfTest;
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    `CHK("pulse idle", 1'b1, invertedPulseOutput)
    apb(0, `CTRL_OFS, 0);
    `CHK("ctrl reset", `CTRL_RESET, rd)
    apb(0, `CMPA_OFS, 0);
    `CHK("cmpA reset", {16'h0, `CMP_RESET}, rd)
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 0);
      `CHK("reg", rows[i].e, rd)
    end
    // event counting with auto-capture, compare A is 3
    apb(1, `CTRL_OFS, ctl(MODE_EVENT, 2'h2, 2'h0, 1, 0, 0, 0));
    apb(1, `CTRL_OFS, ctl(MODE_EVENT, 2'h2, 2'h1, 1, 0, 0, 0));
    i0 = irqCount;
    repeat (2) src.pulse(10, 10);
    apb(0, `CMPB_OFS, 0);
    `CHK("autocap", 32'h2, rd)
    src.level(1, 10);
    `CHK("early irq", i0, irqCount)
    src.level(0, 10);
    `CHK("event irq", i0 + 1, irqCount)
    apb(1, `CTRL_OFS, 0);
    apb(1, `CTRL_OFS, ctl(MODE_WINDOW, 2'h2, 2'h0, 0, 0, 0, 0));
    apb(1, `CTRL_OFS, ctl(MODE_WINDOW, 2'h2, 2'h1, 0, 0, 0, 0));
    i0 = irqCount;
    src.level(0, 100);
    `CHK("win closed", i0, irqCount)
    src.level(1, 100);
    `CHK("win open", 1'b1, irqCount > i0)
    src.level(0, 8);
    apb(1, `CTRL_OFS, 0);
    // single-edge width; high time kept a multiple of the /8 tick
    apb(1, `CTRL_OFS, ctl(MODE_PULSE, 2'h2, 2'h0, 0, 0, 1, 0, 1));
    apb(1, `CTRL_OFS, ctl(MODE_PULSE, 2'h2, 2'h1, 0, 0, 1, 0, 1));
    i0 = irqCount;
    src.level(1, 80);
    `CHK("width early", i0, irqCount)
    src.level(0, 37);
    apb(0, `CMPB_OFS, 0);
    b1 = rd[15:0]; // only used as the reference for the second value
    `CHK("width irq", i0 + 1, irqCount)
    src.level(1, 80);
    src.level(0, 37);
    apb(0, `CMPB_OFS, 0);
    `CHK("width second", b1 + 16'h1, rd[15:0])
    apb(1, `CTRL_OFS, 0);
    // double-edge width: capture at fall, capture and clear at next rise
    apb(1, `CTRL_OFS, ctl(MODE_PULSE, 2'h2, 2'h0, 0, 0, 0, 0, 1));
    apb(1, `CTRL_OFS, ctl(MODE_PULSE, 2'h2, 2'h1, 0, 0, 0, 0, 1));
    i0 = irqCount;
    src.level(1, 80);
    src.level(0, 37);
    apb(0, `CMPB_OFS, 0);
    b1 = rd[15:0];
    src.level(1, 80);
    apb(0, `CMPB_OFS, 0);
    `CHK("double irq", i0 + 2, irqCount)
    `CHK("double period", 1'b1, rd[15:0] > b1)
    apb(1, `CTRL_OFS, 0);
    // one-shot pulse, A 4 and B 2, command start
    apb(1, `CTRL_OFS, ctl(MODE_PULSE, 2'h2, 2'h0, 0, 0, 0, 1));
    apb(1, `CMPA_OFS, 32'h4);
    apb(1, `CMPB_OFS, 32'h2);
    i0 = irqCount;
    t0 = togCount;
    apb(1, `CTRL_OFS, ctl(MODE_PULSE, 2'h2, 2'h3, 0, 0, 0, 1));
    repeat (100) @(posedge clk);
    `CHK("oneshot tog", t0 + 2, togCount)
    `CHK("oneshot irq", i0 + 2, irqCount)
    `CHK("oneshot level", 1'b1, invertedPulseOutput)
    apb(0, `CTRL_OFS, 0);
    `CHK("start cleared", 2'h0, rd[5:4])
    apb(1, `CTRL_OFS, ctl(MODE_PULSE, 2'h2, 2'h3, 0, 0, 0, 0));
    i0 = irqCount;
    t0 = togCount;
    repeat (200) @(posedge clk);
    apb(1, `CTRL_OFS, ctl(MODE_PULSE, 2'h2, 2'h0, 0, 0, 0, 0));
    repeat (4) @(posedge clk);
    `CHK("cont irq", togCount - t0, irqCount - i0)
    `CHK("cont runs", 1'b1, togCount - t0 >= 4)
    t0 = togCount;
    repeat (100) @(posedge clk);
    `CHK("stop hold", t0, togCount)
    apb(1, `CTRL_OFS, 0);
    apb(1, `CTRL_OFS, ctl(MODE_PULSE, 2'h2, 2'h0, 0, 1, 0, 0));
    apb(1, `CTRL_OFS, ctl(MODE_PULSE, 2'h2, 2'h3, 0, 1, 0, 0));
    repeat (4) @(posedge clk);
    `CHK("flop low", 1'b0, invertedPulseOutput)
    reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    `CHK("reset level", 1'b1, invertedPulseOutput)
    apb(0, `CTRL_OFS, 0);
    `CHK("reset ctrl", `CTRL_RESET, rd)
    endOfTest;
  end
endmodule
